// File: rtl/ssp_port.sv
// synchronous serial port, master or slave, with transmit and receive fifos
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module ssp_port import ssp_pkg::*; #(
    parameter int FIFO_DEPTH = SSP_FIFO_WORDS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    output logic miso_pull_en,
    input wire logic ssel_in,
    output logic fault_irq
);
    localparam int PW = $clog2(FIFO_DEPTH);

    function automatic logic msb_of(input logic [15:0] v, input logic c);
        return c ? v[15] : v[7];
    endfunction

    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic sclk_prev_reg;
    logic en_reg;
    logic mst_reg;
    logic chr_reg;
    logic flag_reg;
    logic irqen_reg;
    ssp_cfg_t cfg_reg;
    logic [7:0] div_reg;
    logic [7:0] div_cnt_reg;
    logic [4:0] edge_cnt_reg;
    logic busy_reg;
    logic sh_loaded_reg;
    logic [15:0] sh_reg;
    logic samp_reg;
    logic out_bit_reg;
    logic sclk_reg;
    logic [15:0] tx_mem [FIFO_DEPTH];
    logic [15:0] rx_mem [FIFO_DEPTH];
    logic [PW-1:0] tx_wp_reg;
    logic [PW-1:0] tx_rp_reg;
    logic [PW-1:0] rx_wp_reg;
    logic [PW-1:0] rx_rp_reg;
    logic [PW:0] tx_cnt_reg;
    logic [PW:0] rx_cnt_reg;

    logic sclk_s;
    logic mosi_s;
    logic miso_s;
    logic ssel_s;
    logic sel_act;
    logic wr_data;
    logic rd_data;
    logic wr_ctrl;
    logic [PW:0] cap;
    logic tx_full;
    logic rx_full;
    logic load_direct;
    logic push_tx;
    logic pop_tx;
    logic pop_rx;
    logic start;
    logic tick;
    logic mst_edge;
    logic slv_edge;
    logic lead;
    logic trail;
    logic last;
    logic abort;
    logic fault_ev;
    logic in_bit;
    logic [15:0] shifted;
    logic [15:0] rx_word;
    logic push_rx;

    assign sclk_s = pin_sync_reg[3];
    assign mosi_s = pin_sync_reg[2];
    assign miso_s = pin_sync_reg[1];
    assign ssel_s = pin_sync_reg[0];
    assign sel_act = cfg_reg.select_polarity ? ssel_s : ~ssel_s;
    assign wr_data = wr && addr == SSP_OFF_DATA;
    assign rd_data = rd && addr == SSP_OFF_DATA;
    assign wr_ctrl = wr && addr == SSP_OFF_CTRL;
    assign cap = chr_reg ? (PW+1)'(FIFO_DEPTH / 2) : (PW+1)'(FIFO_DEPTH);
    assign tx_full = tx_cnt_reg >= cap;
    assign rx_full = rx_cnt_reg >= cap;
    assign load_direct = wr_data && !sh_loaded_reg && !busy_reg
        && tx_cnt_reg == '0;
    assign push_tx = wr_data && !load_direct && !tx_full;
    assign pop_tx = tx_cnt_reg != '0 && !sh_loaded_reg && !busy_reg;
    assign pop_rx = rd_data && rx_cnt_reg != '0;
    assign start = en_reg && mst_reg && sh_loaded_reg && !busy_reg;
    assign tick = div_cnt_reg == div_reg;
    assign mst_edge = busy_reg && mst_reg && en_reg && tick;
    assign slv_edge = en_reg && !mst_reg && sel_act
        && sclk_s != sclk_prev_reg;
    assign lead = (mst_edge || slv_edge) && !edge_cnt_reg[0];
    assign trail = (mst_edge || slv_edge) && edge_cnt_reg[0];
    assign last = trail && edge_cnt_reg ==
        (chr_reg ? SSP_LAST_EDGE16 : SSP_LAST_EDGE8);
    assign abort = en_reg && !mst_reg && !sel_act && busy_reg;
    assign fault_ev = en_reg && mst_reg && cfg_reg.fault_detect_enable
        && sel_act;
    assign in_bit = mst_reg ? miso_s : mosi_s;
    assign shifted = {sh_reg[14:0],
        cfg_reg.clock_phase ? in_bit : samp_reg};
    assign rx_word = chr_reg ? shifted : {8'h00, shifted[7:0]};
    assign push_rx = last && !rx_full;

    // pin synchronisers
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
            sclk_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= {sclk_in, mosi_in, miso_in, ssel_in};
            pin_sync_reg <= pin_meta_reg;
            sclk_prev_reg <= sclk_s;
        end
    end

    // control and configuration registers
    always_ff @(posedge clk) begin
        if (reset) begin
            en_reg <= 1'b0;
            mst_reg <= 1'b0;
            chr_reg <= 1'b0;
            irqen_reg <= 1'b0;
            cfg_reg <= SSP_CFG_RESET;
            div_reg <= SSP_DIV_RESET;
        end else begin
            if (wr_ctrl) begin
                en_reg <= wdata[SSP_CTL_EN];
                mst_reg <= wdata[SSP_CTL_MST];
                chr_reg <= wdata[SSP_CTL_CHR];
                irqen_reg <= wdata[SSP_CTL_IRQEN];
            end
            if (wr && addr == SSP_OFF_CFG) begin
                cfg_reg <= ssp_cfg_t'(wdata[3:0]);
            end
            if (wr && addr == SSP_OFF_DIV) begin
                div_reg <= wdata[7:0];
            end
            if (fault_ev) begin
                en_reg <= 1'b0;
                mst_reg <= 1'b0;
            end
        end
    end

    // fault flag, hardware set wins over software clear
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_reg <= 1'b0;
            fault_irq <= 1'b0;
        end else begin
            if (fault_ev) begin
                flag_reg <= 1'b1;
            end else if (wr_ctrl) begin
                flag_reg <= wdata[SSP_CTL_FLAG];
            end
            fault_irq <= flag_reg && irqen_reg;
        end
    end

    // transfer sequencing
    always_ff @(posedge clk) begin
        if (reset) begin
            busy_reg <= 1'b0;
            edge_cnt_reg <= 5'h00;
            div_cnt_reg <= 8'h00;
        end else if (!en_reg || abort || fault_ev) begin
            busy_reg <= 1'b0;
            edge_cnt_reg <= 5'h00;
            div_cnt_reg <= 8'h00;
        end else begin
            if (start || slv_edge) begin
                busy_reg <= !last;
            end else if (last) begin
                busy_reg <= 1'b0;
            end
            if (!busy_reg || tick) begin
                div_cnt_reg <= 8'h00;
            end else begin
                div_cnt_reg <= div_cnt_reg + 8'h01;
            end
            if (last) begin
                edge_cnt_reg <= 5'h00;
            end else if (mst_edge || slv_edge) begin
                edge_cnt_reg <= edge_cnt_reg + 5'h01;
            end
        end
    end

    // shift register and bit output
    always_ff @(posedge clk) begin
        if (reset) begin
            sh_reg <= SSP_WORD_RESET;
            sh_loaded_reg <= 1'b0;
            samp_reg <= 1'b0;
            out_bit_reg <= 1'b0;
        end else begin
            if (load_direct) begin
                sh_reg <= wdata;
                sh_loaded_reg <= 1'b1;
            end else if (pop_tx) begin
                sh_reg <= tx_mem[tx_rp_reg];
                sh_loaded_reg <= 1'b1;
            end else if (trail && en_reg) begin
                sh_reg <= shifted;
                if (last) begin
                    sh_loaded_reg <= 1'b0;
                end
            end
            if (lead && !cfg_reg.clock_phase) begin
                samp_reg <= in_bit;
            end
            if (!busy_reg) begin
                out_bit_reg <= msb_of(sh_reg, chr_reg);
            end else if (trail && !cfg_reg.clock_phase) begin
                out_bit_reg <= msb_of(shifted, chr_reg);
            end else if (lead && cfg_reg.clock_phase) begin
                out_bit_reg <= msb_of(sh_reg, chr_reg);
            end
        end
    end

    // transmit fifo
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_wp_reg <= '0;
            tx_rp_reg <= '0;
            tx_cnt_reg <= '0;
        end else begin
            if (push_tx) begin
                tx_mem[tx_wp_reg] <= wdata;
                tx_wp_reg <= tx_wp_reg + PW'(1);
            end
            if (pop_tx) begin
                tx_rp_reg <= tx_rp_reg + PW'(1);
            end
            tx_cnt_reg <= tx_cnt_reg + (PW+1)'(push_tx) - (PW+1)'(pop_tx);
        end
    end

    // receive fifo
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_wp_reg <= '0;
            rx_rp_reg <= '0;
            rx_cnt_reg <= '0;
        end else begin
            if (push_rx) begin
                rx_mem[rx_wp_reg] <= rx_word;
                rx_wp_reg <= rx_wp_reg + PW'(1);
            end
            if (pop_rx) begin
                rx_rp_reg <= rx_rp_reg + PW'(1);
            end
            rx_cnt_reg <= rx_cnt_reg + (PW+1)'(push_rx) - (PW+1)'(pop_rx);
        end
    end

    // pin drivers
    always_ff @(posedge clk) begin
        if (reset) begin
            sclk_out <= 1'b0;
            sclk_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
            miso_pull_en <= 1'b1;
        end else begin
            if (!busy_reg || !mst_reg) begin
                sclk_out <= cfg_reg.clock_polarity;
            end else if (mst_edge) begin
                sclk_out <= !sclk_out;
            end
            sclk_oe <= en_reg && mst_reg && !fault_ev;
            mosi_oe <= en_reg && mst_reg && !fault_ev;
            mosi_out <= out_bit_reg;
            miso_out <= out_bit_reg;
            miso_oe <= en_reg && !mst_reg && sel_act;
            miso_pull_en <= !(en_reg && !mst_reg && sel_act);
        end
    end

    // register read port
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                SSP_OFF_DATA: rdata <= pop_rx ? rx_mem[rx_rp_reg] : 16'h0000;
                SSP_OFF_CTRL: rdata <= {8'h00, tx_full, rx_cnt_reg != '0,
                    busy_reg, irqen_reg, flag_reg, chr_reg, mst_reg, en_reg};
                SSP_OFF_CFG: rdata <= {12'h000, cfg_reg};
                SSP_OFF_DIV: rdata <= {8'h00, div_reg};
                SSP_OFF_STAT: rdata <= {8'h00, 4'(tx_cnt_reg), 4'(rx_cnt_reg)};
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    fault_drops_port_a: assert property (
        fault_ev |=> !en_reg && !mst_reg && flag_reg ##1 !sclk_oe && !mosi_oe)
        else $error("mode fault did not release the port");
    fault_flag_sticky_a: assert property (
        flag_reg && !wr_ctrl |=> flag_reg)
        else $error("fault flag dropped without a clear");
    sclk_idle_level_a: assert property (
        (!busy_reg && $stable(cfg_reg)) [*2]
        |=> sclk_out == $past(cfg_reg.clock_polarity))
        else $error("idle sclk not at polarity level");
    direct_load_a: assert property (
        load_direct |=> sh_loaded_reg && sh_reg == $past(wdata))
        else $error("write did not reach shift register");
    abort_no_store_a: assert property (
        abort && !pop_rx |=> !busy_reg && rx_cnt_reg == $past(rx_cnt_reg))
        else $error("aborted transfer stored data");
    miso_release_a: assert property (
        (!sel_act || mst_reg) |=> !miso_oe && miso_pull_en)
        else $error("unselected slave drives miso");
    disabled_quiet_a: assert property (
        !en_reg [*2] |-> !sclk_oe && !mosi_oe && !miso_oe && !busy_reg)
        else $error("disabled port still active");
    first_bit_msb_a: assert property (
        start |=> ##1 mosi_out == $past(msb_of(sh_reg, chr_reg), 2))
        else $error("first bit is not the msb");
    rx_push_count_a: assert property (
        push_rx && !pop_rx |=> rx_cnt_reg == $past(rx_cnt_reg) + 1)
        else $error("received character not stored");
    tx_fifo_cap_a: assert property (
        $stable(chr_reg) |-> tx_cnt_reg <= cap && rx_cnt_reg <= cap)
        else $error("fifo above its capacity");
    master_clock_runs_a: assert property (
        start |-> ##[1:600] mst_edge)
        else $error("master start gave no sclk edge");
    slave_pins_input_a: assert property (
        !mst_reg |=> !sclk_oe && !mosi_oe)
        else $error("slave drives sclk or mosi");
    sclk_toggles_a: assert property (
        mst_edge |=> sclk_out != $past(sclk_out))
        else $error("master edge did not toggle sclk");
    selected_drive_a: assert property (
        en_reg && !mst_reg && sel_act |=> miso_oe && !miso_pull_en)
        else $error("selected slave not driving miso");
    fifo_reload_a: assert property (
        pop_tx |=> sh_loaded_reg && sh_reg == $past(tx_mem[tx_rp_reg]))
        else $error("queued character not staged");
    fault_needs_detect_a: assert property (
        !(mst_reg && cfg_reg.fault_detect_enable) && !wr_ctrl
        |=> $stable(flag_reg))
        else $error("fault flagged without detection enabled");
endmodule

// File: shared/ssp_pkg.sv
// constants, field layout and config carrier of the synchronous serial port
// Summary of operation
// - Buffer write loads shift register if it is idle and transmit FIFO empty, else FIFO; reads pop receive FIFO.
// - Shift register is double buffered so the next character waits staged.
// - Unselected slave releases MISO to input with weak pull-up.
// - Characters go most significant bit first on MOSI and MISO.
// - SCLK is driven when master and taken as input when slave.
// - Port works only while the port enable bit is set.
// - Master select chooses master or slave and the SCLK source.
// - Select polarity clear means active-low select; set means active-high.
// - Select released mid-transfer aborts the transaction without storing data.
// - Mode 0: idle low, sample rising, change falling, first bit preset.
// - Mode 1: idle low, change on rising lead, sample on falling trail.
// - Mode 2: idle high, sample falling lead, change rising, first bit preset.
// - Mode 3: idle high, change on falling lead, sample on rising trail.
// - Master transfer starts on buffer write, shifting MOSI while driving SCLK.
// - Master shifts each MISO bit into the low end of the shift register.
// - Master SCLK rate comes from the clock divider register.
// - In master mode select pin is general I/O unless fault detect enabled.
// - Master with fault detect flags a fault when select is at active level.
// - A mode fault disables the port at once, releasing the bus.
// - Fault clears master select and enable, sets flag, interrupts if enabled.
// - Fault flag set by hardware or written 1; stays until cleared or reset.
// - Character length select: clear gives 8 bits, set gives 16 bits.
package ssp_pkg;
    localparam logic [3:0] SSP_OFF_DATA = 4'h0;
    localparam logic [3:0] SSP_OFF_CTRL = 4'h1;
    localparam logic [3:0] SSP_OFF_CFG = 4'h2;
    localparam logic [3:0] SSP_OFF_DIV = 4'h3;
    localparam logic [3:0] SSP_OFF_STAT = 4'h4;
    localparam int SSP_CTL_EN = 0;
    localparam int SSP_CTL_MST = 1;
    localparam int SSP_CTL_CHR = 2;
    localparam int SSP_CTL_FLAG = 3;
    localparam int SSP_CTL_IRQEN = 4;
    localparam int SSP_CTL_BUSY = 5;
    localparam int SSP_CTL_RXNE = 6;
    localparam int SSP_CTL_TXFULL = 7;
    localparam int SSP_FIFO_BITS = 64;
    localparam int SSP_FIFO_WORDS = SSP_FIFO_BITS / 8;
    localparam logic [4:0] SSP_LAST_EDGE8 = 5'h0f;
    localparam logic [4:0] SSP_LAST_EDGE16 = 5'h1f;
    localparam logic [7:0] SSP_DIV_RESET = 8'h00;
    localparam logic [15:0] SSP_WORD_RESET = 16'h0000;
    typedef struct packed {
        logic fault_detect_enable;
        logic select_polarity;
        logic clock_phase;
        logic clock_polarity;
    } ssp_cfg_t;
    localparam ssp_cfg_t SSP_CFG_RESET = 4'h0;
endpackage

// File: bench/ssp_slave_model.sv
// behavioural serial peripheral that answers the port in master mode
`timescale 1ns/1ps
module ssp_slave_model (
    input wire logic clk,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic sel,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic len16,
    input wire logic [15:0] tx_word,
    output logic miso,
    output logic [15:0] last,
    output int frames,
    output int half
);
    logic prev;
    logic [15:0] sh_tx;
    logic [15:0] sh_rx;
    int edges;
    int cyc;
    // released line is pulled up
    assign miso = sel ? sh_tx[15] : 1'b1;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (!sel) begin
            prev = cpol;
            edges = 0;
            sh_tx = len16 ? tx_word : {tx_word[7:0], 8'h00};
        end else if (sclk !== prev) begin
            prev = sclk;
            if (edges > 0)
                half = cyc;
            cyc = 0;
            if ((sclk != cpol) ^ cpha)
                sh_rx = {sh_rx[14:0], mosi};
            else if (!(cpha && edges == 0))
                sh_tx = {sh_tx[14:0], 1'b1};
            edges = edges + 1;
            if (edges == (len16 ? 32 : 16)) begin
                last = len16 ? sh_rx : {8'h00, sh_rx[7:0]};
                frames = frames + 1;
                edges = 0;
                sh_tx = len16 ? tx_word : {tx_word[7:0], 8'h00};
            end
        end
    end
endmodule

// File: bench/sync_serial_port_master_slave_test.sv
// self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module sync_serial_port_master_slave_test import ssp_pkg::*;;
    logic clk, reset, wr, rd, ssel_in, m_sclk, m_mosi, sel;
    logic cpol, cpha, len16, sclk_out, sclk_oe, mosi_out, mosi_oe;
    logic miso_out, miso_oe, miso_pull_en, fault_irq, m_miso;
    logic sclk_w, mosi_w, miso_w;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, s_tx, d, last;
    int half, frames, mismatches, n_compared;
    assign sclk_w = sclk_oe ? sclk_out : m_sclk;
    assign mosi_w = mosi_oe ? mosi_out : m_mosi;
    assign miso_w = miso_oe ? miso_out : m_miso;
    ssp_port i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .sclk_in(sclk_w),
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_in(mosi_w),
        .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
        .miso_out(miso_out), .miso_oe(miso_oe),
        .miso_pull_en(miso_pull_en), .ssel_in(ssel_in),
        .fault_irq(fault_irq));
    ssp_slave_model i_model (.clk(clk), .sclk(sclk_w), .mosi(mosi_w),
        .sel(sel), .cpol(cpol), .cpha(cpha), .len16(len16),
        .tx_word(s_tx), .miso(m_miso), .last(last), .frames(frames),
        .half(half));
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask
    task automatic wait_frames(input int n);
        for (int i = 0; i < 3000 && frames < n; i++)
            @(posedge clk);
        if (frames < n) begin
            mismatches++;
            conclude();
        end
    endtask
    task automatic wait_done();
        int i;
        d = 16'hffff;
        for (i = 0; i < 500 && d[SSP_CTL_BUSY] !== 1'b0; i++)
            rd_reg(SSP_OFF_CTRL, d);
        if (i == 500) begin
            mismatches++;
            conclude();
        end
    endtask
    task automatic setup(input logic [3:0] cfg, input logic [15:0] ctl);
        cpol <= cfg[0];
        cpha <= cfg[1];
        len16 <= ctl[2];
        m_sclk <= cfg[0];
        sel <= 1'b0;
        wr_reg(SSP_OFF_CTRL, 16'h0000);
        wr_reg(SSP_OFF_CFG, {12'h000, cfg});
        wr_reg(SSP_OFF_DIV, 16'h0003);
        wr_reg(SSP_OFF_CTRL, ctl);
    endtask
    task automatic xfer(input logic [3:0] cfg, input logic [15:0] ctl,
        input logic [15:0] tx, input logic [15:0] stx);
        logic [15:0] msk;
        msk = ctl[2] ? 16'hffff : 16'h00ff;
        s_tx <= stx;
        setup(cfg, ctl);
        sel <= 1'b1;
        cycles(4);
        chk("sclk drive", 1, sclk_oe);
        wr_reg(SSP_OFF_DATA, tx);
        wait_frames(frames + 1);
        wait_done();
        chk("mosi word", tx & msk, last);
        chk("sclk half", 16'h0004, half[15:0]);
        chk("sclk idle", cfg[0], sclk_out);
        rd_reg(SSP_OFF_DATA, d);
        chk("miso word", stx & msk, d);
    endtask
    task automatic t_fifo();
        int base;
        s_tx <= 16'h0081;
        setup(4'h0, 16'h0003);
        sel <= 1'b1;
        cycles(2);
        base = frames;
        for (int k = 0; k < 4; k++)
            wr_reg(SSP_OFF_DATA, 16'(8'h61 + 16 * k));
        for (int k = 1; k <= 4; k++) begin
            wait_frames(base + k);
            chk("queued word", 16'(8'h51 + 16 * k), last);
        end
        wait_done();
        rd_reg(SSP_OFF_STAT, d);
        chk("status", 16'h0004, d);
        for (int k = 0; k < 4; k++) begin
            rd_reg(SSP_OFF_DATA, d);
            chk("rx word", 16'h0081, d);
        end
        rd_reg(SSP_OFF_DATA, d);
        chk("rx empty", 16'h0000, d);
    endtask
    task automatic slave_byte(input logic [7:0] pat,
        output logic [7:0] seen);
        for (int k = 7; k >= 0; k--) begin
            m_mosi <= pat[k];
            cycles(8);
            seen[k] = miso_w;
            m_sclk <= 1'b1;
            cycles(8);
            m_sclk <= 1'b0;
        end
        cycles(8);
    endtask
    task automatic t_slave();
        logic [7:0] seen;
        setup(4'h0, 16'h0001);
        cycles(6);
        chk("miso drive", 0, miso_oe);
        chk("miso pull", 1, miso_pull_en);
        chk("sclk drive", 0, sclk_oe);
        wr_reg(SSP_OFF_DATA, 16'h00c3);
        ssel_in <= 1'b0;
        cycles(8);
        chk("miso drive", 1, miso_oe);
        slave_byte(8'h5a, seen);
        ssel_in <= 1'b1;
        chk("slave miso", 16'h00c3, seen);
        cycles(8);
        rd_reg(SSP_OFF_DATA, d);
        chk("slave mosi", 16'h005a, d);
        ssel_in <= 1'b0;
        cycles(8);
        repeat (3) begin
            m_sclk <= 1'b1;
            cycles(8);
            m_sclk <= 1'b0;
            cycles(8);
        end
        ssel_in <= 1'b1;
        cycles(8);
        rd_reg(SSP_OFF_STAT, d);
        chk("abort count", 0, d[3:0]);
        // a bit count left over from the abort would misframe this byte
        ssel_in <= 1'b0;
        cycles(8);
        slave_byte(8'h96, seen);
        ssel_in <= 1'b1;
        cycles(8);
        rd_reg(SSP_OFF_DATA, d);
        chk("abort resync", 16'h0096, d);
    endtask
    task automatic t_fault();
        for (int p = 0; p < 2; p++) begin
            ssel_in <= ~p[0];
            setup({1'b1, p[0], 2'b00}, 16'h0013);
            cycles(6);
            rd_reg(SSP_OFF_CTRL, d);
            chk("ctrl quiet", 16'h0013, d);
            ssel_in <= p[0];
            cycles(6);
            rd_reg(SSP_OFF_CTRL, d);
            chk("ctrl fault", 16'h0018, d);
            chk("oe fault", 0, {sclk_oe, mosi_oe});
            chk("irq", 1, fault_irq);
            ssel_in <= ~p[0];
            wr_reg(SSP_OFF_CTRL, 16'h0010);
            rd_reg(SSP_OFF_CTRL, d);
            chk("flag clear", 16'h0010, d);
            chk("irq", 0, fault_irq);
            wr_reg(SSP_OFF_CTRL, 16'h0018);
            rd_reg(SSP_OFF_CTRL, d);
            chk("flag set", 16'h0018, d);
            chk("irq", 1, fault_irq);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {reset, wr, rd, ssel_in} = 4'h9;
        {m_sclk, m_mosi, sel, cpol, cpha, len16} = 6'h00;
        addr = 4'h0;
        wdata = 16'h0000;
        s_tx = 16'h0000;
        mismatches = 0;
        n_compared = 0;
        cycles(10);
        reset <= 1'b0;
        wr_reg(4'hf, 16'hffff);
        chk("pull reset", 1, miso_pull_en);
        for (int a = 0; a < 16; a++) begin
            rd_reg(a[3:0], d);
            chk("reg reset", 16'h0000, d);
        end
        for (int m = 0; m < 4; m++)
            xfer({2'b00, m[1:0]}, {13'h0000, m[0], 2'b11},
                16'ha53c, 16'h3cc5);
        t_fifo();
        t_slave();
        t_fault();
        setup(4'h0, 16'h0002);
        wr_reg(SSP_OFF_DATA, 16'h0077);
        cycles(100);
        chk("disabled", 0, sclk_oe);
        chk("disabled", 16'h0008, 16'(frames));
        conclude();
    end
endmodule
